// ### src/clbcs_sequencer.sv
// Local bus cycle sequencer, processor side
`timescale 1ns/1ps
module clbcs_sequencer
  import clbcs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Request port from the core
  input wire logic req_valid_i,
  input wire clbcs_req_t req_i,
  output logic req_taken_o,
  output logic cycle_end_o,
  output logic [CLBCS_DATA_W-1:0] rdata_o,
  // Bus pins
  input wire logic cycle_done_n_i,
  input wire logic bus_request_in_i,
  input wire logic [CLBCS_DATA_W-1:0] data_i,
  output logic [CLBCS_DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic phase_clock_o,
  output logic address_strobe_n_o,
  output logic [CLBCS_ADDR_W-1:0] dword_address_o,
  output logic [CLBCS_LANES-1:0] byte_lane_selects_n_o,
  output logic mem_not_io_o,
  output logic data_not_control_o,
  output logic write_not_read_o,
  output logic indivisible_hold_n_o,
  output logic bus_grant_out_o
);

  clbcs_state_t state_r;
  clbcs_state_t state_nxt;
  logic phase_r;
  logic [CLBCS_SYNC_STAGES-1:0] done_sync_r;
  logic [CLBCS_SYNC_STAGES-1:0] breq_sync_r;
  logic [CLBCS_DATA_W-1:0] data_s1_r;
  logic [CLBCS_DATA_W-1:0] data_s2_r;
  logic done_s;
  logic breq_s;
  logic phase_end;
  logic accept;
  logic complete;
  logic drop;
  logic slot_open;

  // Kinds that drive the data pins
  function automatic logic kind_writes(input clbcs_kind_t kind);
    return (kind == CLBCS_IO_WRITE) || (kind == CLBCS_MEM_WRITE);
  endfunction : kind_writes

  // Lock output for a cycle kind, active low
  function automatic logic hold_n_for(input clbcs_kind_t kind, input logic indivisible);
    logic hold_n;
    hold_n = 1'b1;
    unique case (kind)
      CLBCS_INT_ACK: begin
        hold_n = 1'b0;
      end
      CLBCS_MEM_READ, CLBCS_MEM_WRITE: begin
        hold_n = ~indivisible;
      end
      default: begin
        hold_n = 1'b1;
      end
    endcase
    return hold_n;
  endfunction : hold_n_for

  // Fast clock divided by two; phase two ends each bus state
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end
  assign phase_end = phase_r;

  // Pin inputs through two stages, all on the fast rising edge
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_sync_r <= '1;
      breq_sync_r <= '0;
      data_s1_r <= CLBCS_DATA_RST;
      data_s2_r <= CLBCS_DATA_RST;
    end else begin
      done_sync_r <= {done_sync_r[0], cycle_done_n_i};
      breq_sync_r <= {breq_sync_r[0], bus_request_in_i};
      data_s1_r <= data_i;
      data_s2_r <= data_s1_r;
    end
  end
  assign done_s = done_sync_r[CLBCS_SYNC_STAGES-1];
  assign breq_s = breq_sync_r[CLBCS_SYNC_STAGES-1];

  assign complete = phase_end && (state_r == CLBCS_RESP) && !done_s;
  // Illegal code is consumed without a bus cycle
  assign drop = req_valid_i && (req_i.kind == CLBCS_ILLEGAL);
  // A new cycle may begin from idle or as the current one completes
  assign slot_open = (state_r == CLBCS_IDLE) || complete;
  assign accept = phase_end && req_valid_i && !breq_s && !drop && slot_open;

  always_comb begin
    state_nxt = state_r;
    if (phase_end) begin
      unique case (state_r)
        CLBCS_IDLE: begin
          if (breq_s) begin
            state_nxt = CLBCS_GRANT;
          end else if (accept) begin
            state_nxt = CLBCS_FIRST;
          end
        end
        CLBCS_FIRST: begin
          state_nxt = CLBCS_RESP;
        end
        CLBCS_RESP: begin
          if (complete) begin
            if (breq_s) begin
              state_nxt = CLBCS_GRANT;
            end else if (accept) begin
              state_nxt = CLBCS_FIRST;
            end else begin
              state_nxt = CLBCS_IDLE;
            end
          end
        end
        CLBCS_GRANT: begin
          if (!breq_s) begin
            state_nxt = CLBCS_IDLE;
          end
        end
      endcase
    end
  end

  // Cycle state register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= CLBCS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Strobe low only for the first state of a cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      address_strobe_n_o <= 1'b1;
    end else begin
      address_strobe_n_o <= (state_nxt != CLBCS_FIRST);
    end
  end

  // Address, lanes and status latched when a cycle is taken
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dword_address_o <= CLBCS_ADDR_RST;
      byte_lane_selects_n_o <= CLBCS_LANES_IDLE;
      {mem_not_io_o, data_not_control_o, write_not_read_o} <= CLBCS_STATUS_RST;
      indivisible_hold_n_o <= 1'b1;
    end else if (accept) begin
      {mem_not_io_o, data_not_control_o, write_not_read_o} <= req_i.kind;
      if (req_i.kind == CLBCS_HALT_SHUT) begin
        dword_address_o <= CLBCS_ADDR_RST;
        byte_lane_selects_n_o <= req_i.shutdown ? CLBCS_LANES_SHUT : CLBCS_LANES_HALT;
      end else begin
        dword_address_o <= req_i.dword_address;
        byte_lane_selects_n_o <= req_i.lanes_n;
      end
      indivisible_hold_n_o <= hold_n_for(req_i.kind, req_i.indivisible);
    end else if (complete) begin
      indivisible_hold_n_o <= 1'b1;
    end
  end

  // Write data driven from the first state until the cycle ends
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= CLBCS_DATA_RST;
      data_oe_o <= 1'b0;
    end else if (accept) begin
      data_o <= req_i.wdata;
      data_oe_o <= kind_writes(req_i.kind);
    end else if (complete) begin
      data_oe_o <= 1'b0;
    end
  end

  // Core handshake and read data capture
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_taken_o <= 1'b0;
      cycle_end_o <= 1'b0;
      rdata_o <= CLBCS_DATA_RST;
    end else begin
      req_taken_o <= accept || (phase_end && drop && !breq_s && slot_open);
      cycle_end_o <= complete;
      if (complete && !write_not_read_o) begin
        rdata_o <= data_s2_r;
      end
    end
  end

  // Grant shown while the bus is released
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_grant_out_o <= 1'b0;
    end else begin
      bus_grant_out_o <= (state_nxt == CLBCS_GRANT);
    end
  end

  // Phase clock out, low in phase one of each state
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_clock_o <= 1'b0;
    end else begin
      phase_clock_o <= ~phase_r;
    end
  end

endmodule : clbcs_sequencer

// ### src/clbcs_pkg.sv
// Constants, types and behaviour notes for the local bus cycle sequencer
// Notes on behaviour
// - Cycle starts with address, status, strobe low
// - Status code per cycle type as tabled
// - Code LLH never shown with strobe low
// - Halt address 2, shutdown address 0
// - Hold lock for acknowledge, optionally memory
// - Phase clock is fast clock divided two
// - Inputs sampled only on fast rising edges
// - Best case one word per two states
// - Cycle is first state plus response state
// - Address out in first, response in second
// - Done low ends cycle, else wait state
// - Idle keeps strobe high when nothing pending
// - Other master request releases bus, grant shown
package clbcs_pkg;

  localparam int CLBCS_ADDR_W = 30;
  localparam int CLBCS_DATA_W = 32;
  localparam int CLBCS_LANES = 4;
  localparam int CLBCS_SYNC_STAGES = 2;

  // Cycle-type code {mem_not_io, data_not_control, write_not_read}
  typedef enum logic [2:0] {
    CLBCS_INT_ACK = 3'h0,
    CLBCS_ILLEGAL = 3'h1,
    CLBCS_IO_READ = 3'h2,
    CLBCS_IO_WRITE = 3'h3,
    CLBCS_FETCH = 3'h4,
    CLBCS_HALT_SHUT = 3'h5,
    CLBCS_MEM_READ = 3'h6,
    CLBCS_MEM_WRITE = 3'h7
  } clbcs_kind_t;

  typedef enum logic [3:0] {
    CLBCS_IDLE = 4'h1,
    CLBCS_FIRST = 4'h2,
    CLBCS_RESP = 4'h4,
    CLBCS_GRANT = 4'h8
  } clbcs_state_t;

  typedef struct packed {
    clbcs_kind_t kind;
    logic shutdown;
    logic indivisible;
    logic [CLBCS_ADDR_W-1:0] dword_address;
    logic [CLBCS_LANES-1:0] lanes_n;
    logic [CLBCS_DATA_W-1:0] wdata;
  } clbcs_req_t;

  localparam logic [CLBCS_ADDR_W-1:0] CLBCS_ADDR_RST = 30'h0000_0000;
  localparam logic [CLBCS_LANES-1:0] CLBCS_LANES_IDLE = 4'hF;
  localparam logic [CLBCS_LANES-1:0] CLBCS_LANES_HALT = 4'hB;
  localparam logic [CLBCS_LANES-1:0] CLBCS_LANES_SHUT = 4'hE;
  localparam logic [CLBCS_DATA_W-1:0] CLBCS_DATA_RST = 32'h0000_0000;
  localparam logic [2:0] CLBCS_STATUS_RST = 3'h6;

endpackage : clbcs_pkg

// ### bench/clbcs_properties.sv
// Bus cycle timing and status checks bound to the sequencer
`timescale 1ns/1ps
module clbcs_checker
  import clbcs_pkg::*;
(
  // Watched ports
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_taken_o,
  input wire logic cycle_end_o,
  input wire logic cycle_done_n_i,
  input wire logic phase_clock_o,
  input wire logic address_strobe_n_o,
  input wire logic [CLBCS_ADDR_W-1:0] dword_address_o,
  input wire logic [CLBCS_LANES-1:0] byte_lane_selects_n_o,
  input wire logic mem_not_io_o,
  input wire logic data_not_control_o,
  input wire logic write_not_read_o,
  input wire logic indivisible_hold_n_o,
  input wire logic bus_grant_out_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire [2:0] st = {mem_not_io_o, data_not_control_o, write_not_read_o};
  wire strb = !address_strobe_n_o;
  sequence first_state_s;
    strb [*2] ##1 !strb;
  endsequence
  strobe_width_a: assert property ($fell(address_strobe_n_o) |-> first_state_s)
    else $error("strobe width");
  cycle_start_a: assert property ($fell(address_strobe_n_o) |-> req_taken_o && !phase_clock_o
    && $past(req_valid_i) ##1 strb && phase_clock_o) else $error("cycle start");
  no_illegal_a: assert property (strb |-> st != 3'h1) else $error("illegal code");
  halt_addr_a: assert property (strb && st == 3'h5 |-> dword_address_o == '0
    && byte_lane_selects_n_o inside {4'hB, 4'hE}) else $error("halt address");
  hold_kind_a: assert property (strb && st[2:1] != 2'h3 |-> indivisible_hold_n_o == (st != 3'h0))
    else $error("hold kind");
  phase_div_a: assert property (1 |=> phase_clock_o != $past(phase_clock_o)) else $error("phase");
  status_hold_a: assert property (strb |=> $stable({st, dword_address_o, byte_lane_selects_n_o}))
    else $error("status moved");
  done_end_a: assert property (cycle_end_o |-> !$past(cycle_done_n_i, 3)) else $error("end");
  grant_idle_a: assert property (bus_grant_out_o |-> !strb && !req_taken_o) else $error("grant");
  fast_word_a: assert property ($fell(address_strobe_n_o) |=> !cycle_end_o [*3]) else $error("fast");
endmodule : clbcs_checker
bind clbcs_sequencer clbcs_checker clbcs_checker_inst (.*);

// ### bench/clbcs_far_model.sv
// Far-side memory model answering each bus cycle after a set number of waits
`timescale 1ns/1ps
module clbcs_far_model
  import clbcs_pkg::*;
(
  // Clock and bus pins
  input wire logic sys_clk_i,
  input wire logic strobe_n_i,
  input wire logic [CLBCS_ADDR_W-1:0] addr_i,
  input wire logic [3:0] waits_i,
  output logic done_n_o = 1'b1,
  output logic [CLBCS_DATA_W-1:0] data_o = '0
);
  logic strobe_q_r = 1'b1;
  logic [7:0] cnt_r = 8'h00;
  wire [7:0] cnt_nxt = (strobe_q_r && !strobe_n_i) ? 8'h00 : cnt_r + 8'h01;
  always_ff @(posedge sys_clk_i) begin
    strobe_q_r <= strobe_n_i;
    cnt_r <= cnt_nxt;
    done_n_o <= cnt_nxt[7:1] < 7'(waits_i);
    data_o <= (cnt_nxt[7:1] == 7'(waits_i)) ? {addr_i, 2'h2} : ~{addr_i, 2'h2};
  end
endmodule : clbcs_far_model

// ### bench/testbench.sv
// Self-checking bench for the local bus cycle sequencer
`timescale 1ns/1ps
module testbench;
  import clbcs_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, req_valid_i = 0, bus_request_in_i = 0, cycle_done_n_i;
  logic req_taken_o, cycle_end_o, data_oe_o, phase_clock_o, address_strobe_n_o, bus_grant_out_o;
  logic mem_not_io_o, data_not_control_o, write_not_read_o, indivisible_hold_n_o;
  logic [CLBCS_DATA_W-1:0] data_i, data_o, rdata_o;
  logic [CLBCS_ADDR_W-1:0] dword_address_o, a;
  logic [CLBCS_LANES-1:0] byte_lane_selects_n_o;
  logic [3:0] waits = 0;
  clbcs_req_t req_i = '0;
  int n_fail = 0, cmp_count = 0;
  clbcs_sequencer clbcs_sequencer_inst (.*);
  clbcs_far_model clbcs_far_model_inst (.sys_clk_i, .strobe_n_i(address_strobe_n_o),
    .addr_i(dword_address_o), .waits_i(waits), .done_n_o(cycle_done_n_i), .data_o(data_i));
  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic chk(string nm, logic [32:0] seen, logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick
  function automatic logic pick(int s);
    return s == 0 ? req_taken_o : s == 1 ? cycle_end_o : bus_grant_out_o;
  endfunction : pick
  task automatic wait_for(int s);
    for (int i = 0; i < 80 && pick(s) !== 1; i++) tick();
    if (pick(s) !== 1) begin
      n_fail++;
      final_report();
    end
  endtask : wait_for
  task automatic bus_cycle(clbcs_kind_t k, logic sh, logic ind, logic [3:0] w);
    int c;
    waits = w;
    req_i = '{k, sh, ind, 30'h0000_0120 + k, 4'h0, 32'h5A5A_0000 + k};
    req_valid_i = 1;
    wait_for(0);
    req_valid_i = 0;
    a = dword_address_o;
    chk("strobe", address_strobe_n_o, k == CLBCS_ILLEGAL);
    if (k == CLBCS_ILLEGAL) begin
      tick(4);
      chk("idle", address_strobe_n_o, 1);
      return;
    end
    chk("status", {mem_not_io_o, data_not_control_o, write_not_read_o}, k);
    chk("hold", indivisible_hold_n_o, !(k == CLBCS_INT_ACK || ind));
    chk("addr", a, k == CLBCS_HALT_SHUT ? 0 : 30'h0000_0120 + k);
    chk("lanes", byte_lane_selects_n_o, k != CLBCS_HALT_SHUT ? 0 : sh ? 4'hE : 4'hB);
    if (k inside {CLBCS_IO_WRITE, CLBCS_MEM_WRITE}) chk("wdata", {data_oe_o, data_o}, {1'b1, req_i.wdata});
    for (c = 0; c < 60 && cycle_end_o !== 1; c++) tick();
    chk("length", c, 4 + 2 * w);
    if (!k[0]) chk("rdata", rdata_o, {a, 2'h2});
  endtask : bus_cycle
  task automatic back_to_back();
    waits = 0;
    req_i.kind = CLBCS_MEM_READ;
    req_valid_i = 1;
    wait_for(0);
    tick();
    wait_for(0);
    chk("b2b", cycle_end_o, 1);
    req_valid_i = 0;
    tick();
    wait_for(1);
  endtask : back_to_back
  task automatic grant_test();
    bus_request_in_i = 1;
    wait_for(2);
    req_valid_i = 1;
    tick(6);
    chk("held", {bus_grant_out_o, address_strobe_n_o}, 2'h3);
    bus_request_in_i = 0;
    wait_for(0);
    chk("grant", bus_grant_out_o, 0);
    req_valid_i = 0;
    wait_for(1);
  endtask : grant_test
  initial begin
    tick(5);
    chk("reset", {address_strobe_n_o, byte_lane_selects_n_o, mem_not_io_o, data_not_control_o,
      write_not_read_o, bus_grant_out_o}, 9'h1FC);
    rst_i = 0;
    for (int k = 0; k < 8; k++) bus_cycle(clbcs_kind_t'(k), 0, k == 7, 4'(k % 3));
    bus_cycle(CLBCS_HALT_SHUT, 1, 0, 0);
    back_to_back();
    grant_test();
    final_report();
  end
endmodule : testbench
